// *** selfprog_host_pkg.sv ***
// Shared constants and types for the self-programming sequencer controller
package selfprog_host_pkg;

  // Register offsets on the host bus (byte addresses)
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;

  // Field positions in the host registers
  localparam int ADDR_PAGE_LSB = 0;
  localparam int ADDR_WORD_LSB = 8;
  localparam int CFG_IRQ_EN    = 0;
  localparam int CFG_AUTO_REEN = 1;
  localparam int STS_BUSY      = 0;
  localparam int STS_REFUSED   = 1;
  localparam int STS_TIMEOUT   = 2;
  localparam int STS_SEC_BUSY  = 3;
  localparam int STS_OP_EN     = 4;
  localparam int STS_EE_BUSY   = 5;
  localparam int STS_READY_IRQ = 6;
  localparam int STS_RESULT    = 8;

  // Reset values
  localparam logic [15:0] RST_ADDR   = 16'h0000;
  localparam logic [15:0] RST_DATA   = 16'h0000;
  localparam logic [1:0]  RST_CONFIG = 2'h0;

  // Device control register bit positions
  localparam int CR_OP_ENABLE   = 0;
  localparam int CR_SECTION_BSY = 6;
  localparam int CR_IRQ_ENABLE  = 7;

  // Device control register patterns, bit 7 left clear
  localparam logic [7:0] CTL_LOAD  = 8'h01;
  localparam logic [7:0] CTL_ERASE = 8'h03;
  localparam logic [7:0] CTL_WRITE = 8'h05;
  localparam logic [7:0] CTL_LOCK  = 8'h09;
  localparam logic [7:0] CTL_REEN  = 8'h11;

  // Pointer layout and fixed pointer values
  localparam int PTR_PAGE_LSB = 6;
  localparam int PAGE_W       = 7;
  localparam int PTR_WORD_LSB = 1;
  localparam int WORD_W       = 5;
  localparam logic [15:0] PTR_LOCK    = 16'h0001;
  localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
  localparam logic [15:0] PTR_FUSE_HI = 16'h0003;

  // Lock data byte: unused bits forced to one
  localparam logic [7:0] LOCK_ONES = 8'hC3;
  localparam logic [7:0] LOCK_KEEP = 8'h3C;

  // Pages below this index lie in the concurrent section
  localparam logic [PAGE_W-1:0] FIRST_BLOCKING_PAGE = 7'h60;

  // Device answer settles through the synchronisers
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // Longest flash operation and its cycle count
  localparam int FLASH_MAX_US  = 4500;
  localparam int CLK_MHZ       = 20;
  localparam int FLASH_MAX_CYC = FLASH_MAX_US * CLK_MHZ;

  typedef enum logic [2:0] {
    OP_LOAD      = 3'h0,
    OP_ERASE     = 3'h1,
    OP_WRITE     = 3'h2,
    OP_LOCK_SET  = 3'h3,
    OP_REENABLE  = 3'h4,
    OP_LOCK_READ = 3'h5,
    OP_FUSE_LO   = 3'h6,
    OP_FUSE_HI   = 3'h7
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_CTL    = 3'b011,
    ST_STROBE = 3'b010,
    ST_SETTLE = 3'b110,
    ST_POLL   = 3'b111
  } state_t;

endpackage

// *** bit_sync.sv ***
// Two-flop synchroniser for inputs from the device
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** selfprog_host.sv ***
// Host controller that drives the flash self-programming sequencer
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Erase: control 0x03 then store next clock
// - Load: control 0x01, store, word field addresses
// - Never load one buffer word twice
// - Write: control 0x05, word bits zero
// - Re-enable section after programming before reading
// - Lock set: control 0x09, data low byte
// - Lock set uses pointer 0x0001, ones elsewhere
// - Wait EEPROM busy clear before control write
// - Lock read: pointer 0x0001, load within three
// - Fuse low at 0x0000, high at 0x0003
module selfprog_host
  import selfprog_host_pkg::*;
#(
  parameter int TIMEOUT_CYC = FLASH_MAX_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        ctl_wr,
  output var  logic [7:0]  ctl_wdata,
  input  wire logic [7:0]  dev_ctl_rdata,
  output var  logic        store_strobe,
  output var  logic        load_strobe,
  output var  logic [15:0] pointer,
  output var  logic [15:0] data_pair,
  input  wire logic [7:0]  load_result,
  input  wire logic        eeprom_write_busy,
  input  wire logic        ready_irq
);

  state_t             state;
  op_t                cur_op;
  op_t                new_op;
  logic [15:0]        addr_reg;
  logic [15:0]        data_reg;
  logic [1:0]         config_reg;
  logic [31:0]        loaded_map;
  logic [7:0]         read_value;
  logic               refused;
  logic               timed_out;
  logic [2:0]         settle_cnt;
  logic [16:0]        wait_cnt;
  logic [7:0]         dev_status_s;
  logic [7:0]         load_result_s;
  logic [1:0]         misc_s;
  logic               ee_busy_s;
  logic               irq_s;
  logic               ee_busy_prev;
  logic               wb_hit;
  logic               cmd_go;
  logic               accept;
  logic               refuse;
  logic               is_read;
  logic               wait_expired;
  logic               check_ok;
  logic               poll_done;
  logic               chain_reen;
  logic [PAGE_W-1:0]  page_sel;
  logic [WORD_W-1:0]  word_sel;
  logic [WORD_W-1:0]  cur_word;
  logic [31:0]        status_word;
  logic [31:0]        next_rdata;

  // Device inputs cross into this clock through two flops each
  bit_sync #(.WIDTH(8)) u_sync_status (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (dev_ctl_rdata),
    .sync_out (dev_status_s)
  );

  bit_sync #(.WIDTH(8)) u_sync_result (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (load_result),
    .sync_out (load_result_s)
  );

  bit_sync #(.WIDTH(2)) u_sync_misc (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({ready_irq, eeprom_write_busy}),
    .sync_out (misc_s)
  );

  assign ee_busy_s = misc_s[0];
  assign irq_s     = misc_s[1];

  // Field split of the software address register
  assign page_sel = addr_reg[ADDR_PAGE_LSB +: PAGE_W];
  assign word_sel = addr_reg[ADDR_WORD_LSB +: WORD_W];
  assign cur_word = pointer[PTR_WORD_LSB +: WORD_W];
  assign new_op   = op_t'(wb_dat_i[2:0]);

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmd_go = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CMD);

  // A duplicate load would corrupt the buffer word, so it is refused
  assign accept = cmd_go & (state == ST_IDLE)
                & ~((new_op == OP_LOAD) & loaded_map[word_sel]);
  assign refuse = cmd_go & ~accept;

  assign is_read = (cur_op == OP_LOCK_READ) | (cur_op == OP_FUSE_LO)
                 | (cur_op == OP_FUSE_HI);

  assign wait_expired = (wait_cnt == 17'(TIMEOUT_CYC));

  // No control write while EEPROM is busy or a previous op runs
  assign check_ok  = ~ee_busy_s & ~dev_status_s[CR_OP_ENABLE];

  // Erase and write hold the enable bit until finished
  assign poll_done = ~dev_status_s[CR_OP_ENABLE];

  // Optional automatic re-enable after concurrent-section programming
  assign chain_reen = config_reg[CFG_AUTO_REEN]
                    & ((cur_op == OP_ERASE) | (cur_op == OP_WRITE))
                    & (pointer[PTR_PAGE_LSB +: PAGE_W] < FIRST_BLOCKING_PAGE);

  // Sequencer: check, control write, strobe, settle, poll
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state  <= ST_IDLE;
      cur_op <= OP_LOAD;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            cur_op <= new_op;
            state  <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (check_ok) begin
            state <= ST_CTL;
          end else if (wait_expired) begin
            state <= ST_IDLE;
          end
        end
        ST_CTL: begin
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_cnt == 3'h0) begin
            state <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (poll_done) begin
            if (chain_reen) begin
              cur_op <= OP_REENABLE;
              state  <= ST_CHECK;
            end else begin
              state <= ST_IDLE;
            end
          end else if (wait_expired) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Settle and watchdog counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= SETTLE_CYC;
      wait_cnt   <= '0;
    end else begin
      if (state == ST_SETTLE) begin
        settle_cnt <= settle_cnt - 3'h1;
      end else begin
        settle_cnt <= SETTLE_CYC;
      end
      if ((state == ST_CHECK && !check_ok) || (state == ST_POLL && !poll_done)) begin
        wait_cnt <= wait_cnt + 17'h1;
      end else begin
        wait_cnt <= '0;
      end
    end
  end

  // Pointer and data pair latched at command accept, held stable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pointer   <= 16'h0000;
      data_pair <= 16'h0000;
    end else if (accept) begin
      pointer   <= 16'h0000;
      data_pair <= data_reg;
      case (new_op)
        OP_LOAD: begin
          pointer[PTR_WORD_LSB +: WORD_W] <= word_sel;
        end
        OP_ERASE, OP_WRITE: begin
          // Word bits stay zero for page write
          pointer[PTR_PAGE_LSB +: PAGE_W] <= page_sel;
        end
        OP_LOCK_SET: begin
          pointer   <= PTR_LOCK;
          data_pair <= {8'h00, (data_reg[7:0] & LOCK_KEEP) | LOCK_ONES};
        end
        OP_LOCK_READ: begin
          pointer <= PTR_LOCK;
        end
        OP_FUSE_LO: begin
          pointer <= PTR_FUSE_LO;
        end
        OP_FUSE_HI: begin
          pointer <= PTR_FUSE_HI;
        end
        default: begin
          pointer <= 16'h0000;
        end
      endcase
    end
  end

  // Only the documented patterns are ever written
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_wr    <= 1'b0;
      ctl_wdata <= 8'h00;
    end else begin
      ctl_wr <= (state == ST_CHECK) && check_ok;
      if (state == ST_CHECK && check_ok) begin
        case (cur_op)
          OP_LOAD:     ctl_wdata <= CTL_LOAD;
          OP_ERASE:    ctl_wdata <= CTL_ERASE | {config_reg[CFG_IRQ_EN], 7'h00};
          OP_WRITE:    ctl_wdata <= CTL_WRITE | {config_reg[CFG_IRQ_EN], 7'h00};
          OP_REENABLE: ctl_wdata <= CTL_REEN | {config_reg[CFG_IRQ_EN], 7'h00};
          default:     ctl_wdata <= CTL_LOCK | {config_reg[CFG_IRQ_EN], 7'h00};
        endcase
      end
    end
  end

  // Strobe one clock after the control write, inside both windows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      store_strobe <= 1'b0;
      load_strobe  <= 1'b0;
    end else begin
      store_strobe <= (state == ST_CTL) && !is_read;
      load_strobe  <= (state == ST_CTL) && is_read;
    end
  end

  // Mirror of which buffer words hold data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_map <= 32'h0000_0000;
      ee_busy_prev <= 1'b0;
    end else begin
      ee_busy_prev <= ee_busy_s;
      if ((state == ST_POLL && poll_done && cur_op == OP_WRITE)
          || (state == ST_CTL && cur_op == OP_REENABLE)) begin
        loaded_map <= 32'h0000_0000;
      end else if (ee_busy_s && !ee_busy_prev) begin
        loaded_map <= 32'h0000_0000;
      end
      if (state == ST_STROBE && cur_op == OP_LOAD) begin
        loaded_map[cur_word] <= 1'b1;
      end
    end
  end

  // Raw value: programmed bits arrive as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_value <= 8'hFF;
    end else if (state == ST_SETTLE && settle_cnt == 3'h0 && is_read) begin
      read_value <= load_result_s;
    end
  end

  // Sticky error flags, cleared by the next accepted command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refused   <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      if (refuse) begin
        refused <= 1'b1;
      end else if (accept) begin
        refused <= 1'b0;
      end
      if ((state == ST_CHECK && !check_ok && wait_expired)
          || (state == ST_POLL && !poll_done && wait_expired)) begin
        timed_out <= 1'b1;
      end else if (accept) begin
        timed_out <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg   <= RST_ADDR;
      data_reg   <= RST_DATA;
      config_reg <= RST_CONFIG;
    end else if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        OFS_ADDR: begin
          if (wb_sel_i[0]) addr_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) addr_reg[15:8] <= wb_dat_i[15:8];
        end
        OFS_DATA: begin
          if (wb_sel_i[0]) data_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) data_reg[15:8] <= wb_dat_i[15:8];
        end
        OFS_CONFIG: begin
          if (wb_sel_i[0]) config_reg <= wb_dat_i[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Section busy and ready request shown as the device reports them
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_BUSY]      = (state != ST_IDLE);
    status_word[STS_REFUSED]   = refused;
    status_word[STS_TIMEOUT]   = timed_out;
    status_word[STS_SEC_BUSY]  = dev_status_s[CR_SECTION_BSY];
    status_word[STS_OP_EN]     = dev_status_s[CR_OP_ENABLE];
    status_word[STS_EE_BUSY]   = ee_busy_s;
    status_word[STS_READY_IRQ] = irq_s;
    status_word[STS_RESULT +: 8] = read_value;
  end

  always_comb begin
    case (wb_adr_i)
      OFS_CMD:    next_rdata = {29'h0, cur_op};
      OFS_ADDR:   next_rdata = {16'h0000, addr_reg};
      OFS_DATA:   next_rdata = {16'h0000, data_reg};
      OFS_STATUS: next_rdata = status_word;
      OFS_CONFIG: next_rdata = {30'h0, config_reg};
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  // Every access acks after one cycle; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// *** selfprog_host_checker.sv ***
// Port checker for the self-programming host controller
`timescale 1ns/10ps
`default_nettype none
module selfprog_host_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ctl_wr,
  input wire logic [7:0]  ctl_wdata,
  input wire logic [7:0]  dev_ctl_rdata,
  input wire logic        store_strobe,
  input wire logic        load_strobe,
  input wire logic [15:0] pointer,
  input wire logic [15:0] data_pair,
  input wire logic [7:0]  load_result,
  input wire logic        eeprom_write_busy,
  input wire logic        ready_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_cmd;
    ctl_wr ##1 (store_strobe || load_strobe);
  endsequence
  sequence s_ee_held;
    eeprom_write_busy [*4];
  endsequence
  a_ctl_then_strobe: assert property (ctl_wr |-> s_cmd)
    else $error("no strobe after control write");
  a_strobe_has_ctl: assert property ((store_strobe || load_strobe) |-> $past(ctl_wr))
    else $error("strobe without control write");
  a_ee_blocks_ctl: assert property (s_ee_held |-> !ctl_wr)
    else $error("control write during eeprom write");
  a_pattern_legal: assert property (ctl_wr |-> ctl_wdata[6:0] inside {7'h01, 7'h03, 7'h05, 7'h09, 7'h11})
    else $error("illegal control pattern");
  a_load_no_irq: assert property (ctl_wr && ctl_wdata[6:0] == 7'h01 |-> !ctl_wdata[7])
    else $error("load pattern not plain");
  a_write_word_zero: assert property (store_strobe && ctl_wdata[3:0] == 4'h5 |-> pointer[5:0] == 6'h00)
    else $error("page write with word bits set");
  a_lock_args: assert property (store_strobe && ctl_wdata[3:0] == 4'h9
    |-> pointer == 16'h0001 && (data_pair[7:0] & 8'hC3) == 8'hC3)
    else $error("lock set arguments wrong");
  a_read_setup: assert property (load_strobe |-> ctl_wdata[4:0] == 5'h09 && pointer inside {16'h0000, 16'h0001, 16'h0003})
    else $error("read not armed correctly");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late or long");
endmodule
bind selfprog_host selfprog_host_checker selfprog_host_checker_inst (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctl_wr, .ctl_wdata, .dev_ctl_rdata, .store_strobe,
  .load_strobe, .pointer, .data_pair, .load_result, .eeprom_write_busy, .ready_irq);
`default_nettype wire

// *** flash_seq_model.sv ***
// Behavioural model of the flash sequencer behind the host controller
`timescale 1ns/10ps
`default_nettype none
module flash_seq_model #(
  parameter logic [7:0] FUSE_LO_VAL = 8'hE1,
  parameter logic [7:0] FUSE_HI_VAL = 8'h99,
  parameter int         BUSY_CYC    = 20
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ctl_wr,
  input  wire logic [7:0]  ctl_wdata,
  input  wire logic        store_strobe,
  input  wire logic        load_strobe,
  input  wire logic [15:0] pointer,
  input  wire logic [15:0] data_pair,
  input  wire logic        eeprom_write_busy,
  output var  logic [7:0]  dev_ctl_rdata,
  output var  logic [7:0]  load_result,
  output var  logic        ready_irq,
  output var  logic [7:0]  last_ctl,
  output var  logic [15:0] last_ptr,
  output var  logic [15:0] last_data,
  output var  logic [7:0]  n_stores,
  output var  logic        dbl_load
);
  logic [7:0]  ctl;
  logic [7:0]  lock;
  logic [7:0]  rd_val;
  logic [31:0] loaded;
  logic        sec_busy;
  logic        ee_q;
  int          cnt;
  int          hold;
  assign dev_ctl_rdata = {1'b0, sec_busy, 5'h00, ctl[0]};
  assign ready_irq     = ctl[7] & ~ctl[0];
  assign load_result   = (hold > 0) ? rd_val : ~rd_val; // Stale byte never lingers after the read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {loaded, sec_busy, dbl_load, ee_q} <= '0;
      {last_ctl, last_ptr, last_data, n_stores} <= '0;
      lock <= 8'hFF;
      rd_val <= 8'hFF;
      hold <= 0;
      // An erase or write already started runs on through reset
      if (cnt > 1 && ctl[2:1] != 2'b00) begin
        cnt <= cnt - 1;
      end else begin
        ctl <= 8'h00;
        cnt <= 0;
      end
    end else begin
      ee_q <= eeprom_write_busy;
      if (eeprom_write_busy && !ee_q) loaded <= '0;
      if (hold > 0) hold <= hold - 1;
      if (cnt > 0) cnt <= cnt - 1;
      if (ctl_wr) begin
        ctl <= ctl_wdata;
        cnt <= 4;
      end else if (cnt == 1) begin
        ctl[4:0] <= 5'h00;
      end
      if (store_strobe && ctl[0]) begin
        {last_ctl, last_ptr, last_data} <= {ctl, pointer, data_pair};
        n_stores <= n_stores + 8'h01;
        cnt <= 1;
        case (ctl[4:0])
          5'h01: begin
            if (loaded[pointer[5:1]]) dbl_load <= 1'b1;
            loaded[pointer[5:1]] <= 1'b1;
          end
          5'h03, 5'h05: begin
            cnt <= BUSY_CYC;
            // Blocking-section pages leave the flag clear; the halted CPU is not modelled
            if (pointer[12:6] < 7'h60) sec_busy <= 1'b1;
            if (ctl[2]) loaded <= '0;
          end
          5'h09: lock <= lock & (data_pair[7:0] | 8'hC3);
          5'h11: {sec_busy, loaded} <= '0;
          default: ;
        endcase
      end
      if (load_strobe && ctl[4:0] == 5'h09) begin
        rd_val <= (pointer == 16'h0001) ? {2'b11, lock[5:0]} : (pointer == 16'h0000) ? FUSE_LO_VAL : FUSE_HI_VAL;
        hold <= 8;
        cnt <= 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test_selfprog_host.sv ***
// Self-checking bench for the self-programming host controller
`timescale 1ns/10ps
`default_nettype none
module test_selfprog_host;
  import selfprog_host_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        ee = 1'b0;
  logic [31:0] st;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, ctl_wr, store_strobe, load_strobe, ready_irq, dbl_load;
  logic [7:0]  ctl_wdata, dev_ctl_rdata, load_result, last_ctl, n_stores;
  logic [15:0] pointer, data_pair, last_ptr, last_data;
  int          err_total = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #25 clk = ~clk;
  selfprog_host #(.TIMEOUT_CYC(200)) selfprog_host_inst (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .ctl_wr, .ctl_wdata,
    .dev_ctl_rdata, .store_strobe, .load_strobe, .pointer, .data_pair, .load_result,
    .eeprom_write_busy(ee), .ready_irq);
  flash_seq_model flash_seq_model_inst (.clk, .reset_n, .ctl_wr, .ctl_wdata, .store_strobe, .load_strobe,
    .pointer, .data_pair, .eeprom_write_busy(ee), .dev_ctl_rdata, .load_result, .ready_irq, .last_ctl,
    .last_ptr, .last_data, .n_stores, .dbl_load);
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    st = wb_dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic run(input logic [2:0] op);
    wb(1'b1, OFS_CMD, {29'h0, op});
    do wb(1'b0, OFS_STATUS, 32'h0); while (st[STS_BUSY] !== 1'b0);
  endtask
  task automatic t_reset;
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(st[15:0], 16'hFF00);
    wb(1'b0, 8'h20, 32'h0);
    chk(st[15:0], 16'h0000);
  endtask
  task automatic t_load;
    wb(1'b1, OFS_ADDR, 32'h0305);
    wb(1'b1, OFS_DATA, 32'hA55A);
    run(OP_LOAD);
    chk({8'h00, last_ctl}, {8'h00, CTL_LOAD});
    chk(last_ptr, 16'h0006);
    chk(last_data, 16'hA55A);
    run(OP_LOAD);
    chk({15'h0, st[STS_REFUSED]}, 16'h0001);
    chk({8'h00, n_stores}, 16'h0001);
  endtask
  task automatic t_erase;
    run(OP_ERASE);
    chk({8'h00, last_ctl}, {8'h00, CTL_ERASE});
    chk(last_ptr, 16'h0140);
    chk({15'h0, st[STS_SEC_BUSY]}, 16'h0001);
    run(OP_REENABLE);
    chk({8'h00, last_ctl}, {8'h00, CTL_REEN});
    chk({15'h0, st[STS_SEC_BUSY]}, 16'h0000);
    run(OP_LOAD);
    chk({15'h0, st[STS_REFUSED]}, 16'h0000);
  endtask
  task automatic t_write;
    wb(1'b1, OFS_CONFIG, 32'h1);
    run(OP_WRITE);
    chk({8'h00, last_ctl}, {8'h00, CTL_WRITE | 8'h80});
    chk(last_ptr, 16'h0140);
    chk({15'h0, st[STS_READY_IRQ]}, 16'h0001);
    wb(1'b1, OFS_CONFIG, 32'h2);
    run(OP_ERASE);
    chk({8'h00, last_ctl}, {8'h00, CTL_REEN});
    chk({15'h0, st[STS_SEC_BUSY]}, 16'h0000);
    wb(1'b1, OFS_CONFIG, 32'h0);
  endtask
  task automatic t_lock;
    wb(1'b1, OFS_DATA, 32'h0010);
    run(OP_LOCK_SET);
    chk({8'h00, last_ctl}, {8'h00, CTL_LOCK});
    chk(last_ptr, PTR_LOCK);
    chk({8'h00, last_data[7:0]}, 16'h00D3);
    chk({15'h0, st[STS_SEC_BUSY]}, 16'h0000);
    run(OP_LOCK_READ);
    chk({8'h00, st[15:8]}, 16'h00D3);
    run(OP_FUSE_LO);
    chk({8'h00, st[15:8]}, 16'h00E1);
    run(OP_FUSE_HI);
    chk({8'h00, st[15:8]}, 16'h0099);
  endtask
  task automatic t_eeprom;
    wb(1'b1, OFS_ADDR, 32'h0905);
    run(OP_LOAD);
    ee <= 1'b1;
    wb(1'b1, OFS_CMD, {29'h0, OP_LOCK_READ});
    repeat (30) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk({15'h0, st[STS_BUSY]}, 16'h0001);
    chk({8'h00, last_ctl}, {8'h00, CTL_LOAD});
    ee <= 1'b0;
    do wb(1'b0, OFS_STATUS, 32'h0); while (st[STS_BUSY] !== 1'b0);
    chk({8'h00, st[15:8]}, 16'h00D3);
    run(OP_LOAD);
    chk({15'h0, st[STS_REFUSED]}, 16'h0000);
    chk({15'h0, dbl_load}, 16'h0000);
  endtask
  task automatic t_midreset;
    wb(1'b1, OFS_CMD, {29'h0, OP_ERASE});
    repeat (4) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk({11'h0, st[4:0]}, 16'h0010);
    run(OP_LOAD);
    chk({13'h0, st[2:0]}, 16'h0000);
    chk({8'h00, n_stores}, 16'h0001);
    chk({8'h00, last_ctl}, {8'h00, CTL_LOAD});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_load();
    t_erase();
    t_write();
    t_lock();
    t_eeprom();
    t_midreset();
    end_sim();
  end
endmodule
`default_nettype wire
